/* design/ubg_defs.vh */
`ifndef UBG_DEFS_VH
`define UBG_DEFS_VH
// register indexes on the 3-bit address
`define UBG_ADDR_DATA 3'h0
`define UBG_ADDR_IER 3'h1
`define UBG_ADDR_IIR 3'h2
`define UBG_ADDR_LCR 3'h3
`define UBG_ADDR_MCR 3'h4
`define UBG_ADDR_LSR 3'h5
`define UBG_ADDR_MSR 3'h6
`define UBG_ADDR_SCR 3'h7
// field positions
`define UBG_LCR_DIV_SEL 7
`define UBG_LSR_TX_HOLDING_EMPTY 5
`define UBG_LSR_TX_ALL_EMPTY 6
`define UBG_MCR_LOOP 4
// reset values and interrupt id codes
`define UBG_LSR_RESET 8'h60
`define UBG_IIR_NONE 8'h01
`define UBG_IIR_RLS 8'h06
`define UBG_IIR_RDA 8'h04
`define UBG_IIR_TX_HOLDING_EMPTY 8'h02
`define UBG_IIR_MSI 8'h00
// timing: 16x clock ticks per bit, start sample at 7.5 ticks
`define UBG_TICKS_PER_BIT 4'hf
`define UBG_START_SAMPLE 4'h7
`define UBG_DIV_RESET 16'h000c
`endif

/* design/ubg_baud_div.v */
`timescale 1ns/1ns
// programmable divider: one 16x enable pulse every divisor clocks
module ubg_baud_div (
   input wire CLK_I,
   input wire RST_I,
   input wire [15:0] divisor_i,
   input wire reload_i,
   output reg tick_o
);
   reg [15:0] count;
   wire [15:0] div_eff;

   // a zero divisor would stall the generator, treat it as one
   assign div_eff = (divisor_i == 16'h0000) ? 16'h0001 : divisor_i;

   // counter restarts on any divisor write so a new rate applies at once
   always @(posedge CLK_I) begin
      if (RST_I || reload_i) begin
         count <= 16'h0001;
         tick_o <= 1'b0;
      end else if (count >= div_eff) begin
         count <= 16'h0001;
         tick_o <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule // ubg_baud_div

/* design/ubg_uart.v */
`timescale 1ns/1ns
// Summary of operation
// - divide input clock by 16-bit divisor, 16x out
// - divisor one passes input undivided
// - reset reinitializes transmit and receive counters
// - reset clears line status except bits 5,6
// - reset clears line and modem control
// - reset keeps divisor, receive and transmit data
// - idle after reset until host programs
// - reset clears interrupt enables, bits 4-7 zero
// - interrupt id reads 01 after reset
// - reset clears modem change bits, upper live
// - reset drives serial and modem outputs high
// - enabling transmit interrupt after reset fires it
// - each interrupt cleared by its own access
// - works up to 10 MHz input clock
// - bit 7 selects divisor latch access
// - start bit checked at count 7.5
`include "ubg_defs.vh"
module ubg_uart (
   input wire CLK_I,
   input wire RST_I,
   input wire [2:0] ADDR_I,
   input wire [7:0] DAT_I,
   output reg [7:0] DAT_O,
   input wire CS_I,
   input wire RD_I,
   input wire WR_I,
   input wire SERIAL_IN_I,
   input wire CTS_N_I,
   input wire DSR_N_I,
   input wire RI_N_I,
   input wire DCD_N_I,
   output wire SERIAL_OUTPUT_O,
   output wire BAUD_CLOCK_OUT_O,
   output wire DTR_N_O,
   output wire RTS_N_O,
   output wire USER_OUTPUT_ONE_N_O,
   output wire USER_OUTPUT_TWO_N_O,
   output wire INTR_O
);
   reg [7:0] baud_divisor_low;
   reg [7:0] baud_divisor_high;
   reg [7:0] line_control_reg;
   reg [4:0] modem_control_reg;
   reg [3:0] interrupt_enable_reg;
   reg [7:0] tx_holding_reg;
   reg [7:0] rx_buffer_reg;
   reg [7:0] scratch_reg;
   reg data_ready, overrun, parity_err, framing_err, break_int;
   reg tx_holding_empty, tx_all_empty;
   reg [3:0] modem_delta;
   reg [3:0] modem_prev;
   reg tx_holding_empty_pending;
   reg [7:0] tx_shift;
   reg [3:0] tx_bits;
   reg [3:0] tx_tick;
   reg tx_busy;
   reg tx_line;
   reg [1:0] rx_state;
   reg [3:0] rx_tick;
   reg [3:0] rx_bits;
   reg [7:0] rx_shift;
   reg rx_prev;
   wire baud_tick;
   wire div_sel;
   wire rd_s;
   wire wr_s;
   wire [3:0] modem_live;
   wire [7:0] line_status_reg;
   wire [7:0] modem_status_reg;
   wire [7:0] interrupt_id_reg;
   wire rx_in;
   wire [3:0] char_bits;

   localparam RX_IDLE = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA = 2'b10;
   localparam RX_STOP = 2'b11;

   // word length field 0..3 maps to 5..8 data bits
   function [3:0] word_len;
      input [1:0] sel;
      begin
         word_len = {2'b00, sel} + 4'h5;
      end
   endfunction

   assign rd_s = CS_I & RD_I;
   assign wr_s = CS_I & WR_I;
   assign div_sel = line_control_reg[`UBG_LCR_DIV_SEL];
   assign char_bits = word_len(line_control_reg[1:0]);
   // pins are active low, status shows asserted as one
   assign modem_live = {~DCD_N_I, ~RI_N_I, ~DSR_N_I, ~CTS_N_I};
   assign modem_status_reg = {modem_live, modem_delta};
   assign line_status_reg = {1'b0, tx_all_empty, tx_holding_empty, break_int,
                             framing_err, parity_err, overrun, data_ready};

   // priority encoded identification, bit 0 low when pending
   assign interrupt_id_reg =
      (interrupt_enable_reg[2] & (overrun | parity_err | framing_err | break_int)) ?
         `UBG_IIR_RLS :
      (interrupt_enable_reg[0] & data_ready) ? `UBG_IIR_RDA :
      (interrupt_enable_reg[1] & tx_holding_empty_pending) ? `UBG_IIR_TX_HOLDING_EMPTY :
      (interrupt_enable_reg[3] & (|modem_delta)) ? `UBG_IIR_MSI :
      `UBG_IIR_NONE;
   assign INTR_O = ~interrupt_id_reg[0];

   // loop mode keeps the pin at mark and feeds transmit back internally
   assign rx_in = modem_control_reg[`UBG_MCR_LOOP] ? tx_line : SERIAL_IN_I;
   assign SERIAL_OUTPUT_O = modem_control_reg[`UBG_MCR_LOOP] ? 1'b1 : tx_line;
   assign DTR_N_O = ~modem_control_reg[0];
   assign RTS_N_O = ~modem_control_reg[1];
   assign USER_OUTPUT_ONE_N_O = ~modem_control_reg[2];
   assign USER_OUTPUT_TWO_N_O = ~modem_control_reg[3];
   assign BAUD_CLOCK_OUT_O = baud_tick;

   ubg_baud_div u_div (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .divisor_i({baud_divisor_high, baud_divisor_low}),
      .reload_i(wr_s & div_sel & (ADDR_I[2:1] == 2'b00)),
      .tick_o(baud_tick)
   );

   // divisor, data and scratch survive master reset
   always @(posedge CLK_I) begin
      if (wr_s) begin
         case (ADDR_I)
            `UBG_ADDR_DATA: begin
               if (div_sel)
                  baud_divisor_low <= DAT_I;
               else
                  tx_holding_reg <= DAT_I;
            end
            `UBG_ADDR_IER: begin
               if (div_sel)
                  baud_divisor_high <= DAT_I;
            end
            `UBG_ADDR_SCR: scratch_reg <= DAT_I;
            default: ;
         endcase
      end
   end

   // control registers cleared by master reset
   always @(posedge CLK_I) begin
      if (RST_I) begin
         line_control_reg <= 8'h00;
         modem_control_reg <= 5'h00;
         interrupt_enable_reg <= 4'h0;
      end else if (wr_s) begin
         case (ADDR_I)
            `UBG_ADDR_IER: begin
               if (!div_sel)
                  interrupt_enable_reg <= DAT_I[3:0];
            end
            `UBG_ADDR_LCR: line_control_reg <= DAT_I;
            `UBG_ADDR_MCR: modem_control_reg <= DAT_I[4:0];
            default: ;
         endcase
      end
   end

   // read mux, registered data out
   always @(posedge CLK_I) begin
      if (RST_I)
         DAT_O <= 8'h00;
      else if (rd_s) begin
         case (ADDR_I)
            `UBG_ADDR_DATA: DAT_O <= div_sel ? baud_divisor_low : rx_buffer_reg;
            `UBG_ADDR_IER: DAT_O <= div_sel ? baud_divisor_high :
                                   {4'h0, interrupt_enable_reg};
            `UBG_ADDR_IIR: DAT_O <= interrupt_id_reg;
            `UBG_ADDR_LCR: DAT_O <= line_control_reg;
            `UBG_ADDR_MCR: DAT_O <= {3'b000, modem_control_reg};
            `UBG_ADDR_LSR: DAT_O <= line_status_reg;
            `UBG_ADDR_MSR: DAT_O <= modem_status_reg;
            default: DAT_O <= scratch_reg;
         endcase
      end
   end

   // modem change detect; a new change wins over the clearing read
   always @(posedge CLK_I) begin
      if (RST_I) begin
         modem_delta <= 4'h0;
         modem_prev <= modem_live;
      end else begin
         modem_prev <= modem_live;
         modem_delta <= ((rd_s && ADDR_I == `UBG_ADDR_MSR) ? 4'h0 : modem_delta) |
                        {modem_live[3] ^ modem_prev[3], modem_prev[2] & ~modem_live[2],
                         modem_live[1:0] ^ modem_prev[1:0]};
      end
   end

   // transmitter: holding register, shift register, 16 ticks per bit
   always @(posedge CLK_I) begin
      if (RST_I) begin
         tx_holding_empty <= 1'b1;
         tx_all_empty <= 1'b1;
         tx_holding_empty_pending <= 1'b1;
         tx_busy <= 1'b0;
         tx_line <= 1'b1;
         tx_tick <= 4'h0;
         tx_bits <= 4'h0;
         tx_shift <= 8'h00;
      end else begin
         if (wr_s && ADDR_I == `UBG_ADDR_DATA && !div_sel) begin
            tx_holding_empty <= 1'b0;
            tx_holding_empty_pending <= 1'b0;
         end else if (rd_s && ADDR_I == `UBG_ADDR_IIR &&
                      interrupt_id_reg == `UBG_IIR_TX_HOLDING_EMPTY)
            tx_holding_empty_pending <= 1'b0;
         if (!tx_busy && !tx_holding_empty && baud_tick) begin
            tx_busy <= 1'b1; // idle until host writes data
            tx_all_empty <= 1'b0;
            tx_holding_empty <= 1'b1;
            tx_holding_empty_pending <= 1'b1;
            tx_shift <= tx_holding_reg;
            tx_line <= 1'b0;
            tx_tick <= 4'h0;
            tx_bits <= 4'h0;
         end else if (tx_busy && baud_tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `UBG_TICKS_PER_BIT) begin
               // stop bit after char_bits data bits; parity not generated here
               if (tx_bits == char_bits + 4'h1) begin
                  tx_busy <= 1'b0;
                  tx_all_empty <= 1'b1;
                  tx_line <= 1'b1;
               end else begin
                  tx_bits <= tx_bits + 4'h1;
                  tx_line <= (tx_bits == char_bits) ? 1'b1 : tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[7:1]};
               end
            end
         end
         if (line_control_reg[6] && tx_busy)
            tx_line <= 1'b0; // break forces space only while a character is being sent
      end
   end

   // receiver: falling edge, confirm at mid start bit, sample mid data bits
   always @(posedge CLK_I) begin
      if (RST_I) begin
         rx_state <= RX_IDLE;
         rx_tick <= 4'h0;
         rx_bits <= 4'h0;
         rx_shift <= 8'h00;
         rx_prev <= 1'b1;
         data_ready <= 1'b0;
         overrun <= 1'b0;
         parity_err <= 1'b0;
         framing_err <= 1'b0;
         break_int <= 1'b0;
      end else begin
         if (rd_s && ADDR_I == `UBG_ADDR_DATA && !div_sel)
            data_ready <= 1'b0;
         if (rd_s && ADDR_I == `UBG_ADDR_LSR) begin
            overrun <= 1'b0;
            parity_err <= 1'b0;
            framing_err <= 1'b0;
            break_int <= 1'b0;
         end
         if (baud_tick) begin
            rx_prev <= rx_in;
            case (rx_state)
               RX_IDLE: begin
                  rx_tick <= 4'h0;
                  if (rx_prev && !rx_in)
                     rx_state <= RX_START;
               end
               RX_START: begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == `UBG_START_SAMPLE) begin
                     rx_tick <= 4'h0;
                     rx_bits <= 4'h0;
                     rx_state <= rx_in ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == `UBG_TICKS_PER_BIT) begin
                     rx_shift <= {rx_in, rx_shift[7:1]};
                     rx_bits <= rx_bits + 4'h1;
                     if (rx_bits + 4'h1 == char_bits)
                        rx_state <= RX_STOP;
                  end
               end
               default: begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == `UBG_TICKS_PER_BIT) begin
                     rx_state <= RX_IDLE;
                     rx_buffer_reg <= rx_shift >> (4'h8 - char_bits);
                     data_ready <= 1'b1; // set wins over clearing read
                     overrun <= data_ready | overrun;
                     framing_err <= ~rx_in;
                     break_int <= ~rx_in & ~(|rx_shift);
                  end
               end
            endcase
         end
      end
   end
endmodule // ubg_uart

/* tb/ubg_uart_properties.sv */
`timescale 1ns/1ns
module ubg_uart_properties (
   input wire CLK_I,
   input wire RST_I,
   input wire [2:0] ADDR_I,
   input wire [7:0] DAT_I,
   input wire [7:0] DAT_O,
   input wire CS_I,
   input wire RD_I,
   input wire WR_I,
   input wire SERIAL_OUTPUT_O,
   input wire BAUD_CLOCK_OUT_O,
   input wire DTR_N_O,
   input wire RTS_N_O,
   input wire USER_OUTPUT_ONE_N_O,
   input wire USER_OUTPUT_TWO_N_O,
   input wire INTR_O
);
   reg divisor_access_select;
   reg fresh;
   reg tx_holding_empty_ok;
   reg [1:0] seen;
   reg [15:0] div;
   reg [15:0] gap;
   wire wr = CS_I && WR_I;
   wire rd = CS_I && RD_I;
   wire div_wr = wr && divisor_access_select && ADDR_I[2:1] == 2'h0;
   wire [15:0] div_eff = (div == 16'h0000) ? 16'h0001 : div;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // divisor shadow has no reset, like the latches it mirrors
   always @(posedge CLK_I) begin
      if (div_wr && !ADDR_I[0]) div[7:0] <= DAT_I;
      if (div_wr && ADDR_I[0]) div[15:8] <= DAT_I;
      gap <= BAUD_CLOCK_OUT_O ? 16'h0001 : gap + 16'h0001;
   end
   // skip two pulses after a reload, the first gap may be long
   always @(posedge CLK_I) begin
      if (RST_I) begin
         divisor_access_select <= 1'b0;
         fresh <= 1'b1;
         tx_holding_empty_ok <= 1'b1;
         seen <= 2'h0;
      end else begin
         if (wr && ADDR_I == 3'h3) divisor_access_select <= DAT_I[7];
         if (div_wr) seen <= 2'h0;
         else if (BAUD_CLOCK_OUT_O && seen != 2'h2) seen <= seen + 2'h1;
         if (wr) fresh <= 1'b0;
         if ((wr && !divisor_access_select && ADDR_I == 3'h0) || (rd && ADDR_I == 3'h2)) tx_holding_empty_ok <= 1'b0;
      end
   end
   sequence s_fresh_rd(logic [2:0] a);
      fresh && rd && ADDR_I == a;
   endsequence
   sequence s_tx_holding_empty_on;
      tx_holding_empty_ok && wr && !divisor_access_select && ADDR_I == 3'h1 && DAT_I[1];
   endsequence
   a_pins_high: assert property ($fell(RST_I) |-> DTR_N_O && RTS_N_O
      && USER_OUTPUT_ONE_N_O && USER_OUTPUT_TWO_N_O) else $error("modem pins low after reset");
   a_stay_idle: assert property ($fell(RST_I) |-> (SERIAL_OUTPUT_O && !INTR_O) [*8])
      else $error("activity right after reset");
   a_tick_spacing: assert property (seen == 2'h2 && (BAUD_CLOCK_OUT_O || gap == div_eff)
      |-> BAUD_CLOCK_OUT_O && gap == div_eff) else $error("baud pulse spacing wrong");
   a_tx_holding_empty_irq: assert property (s_tx_holding_empty_on |=> INTR_O) else $error("no tx empty interrupt");
   a_iir_reset: assert property (s_fresh_rd(3'h2) |=> DAT_O == 8'h01)
      else $error("interrupt id wrong after reset");
   a_lsr_reset: assert property (s_fresh_rd(3'h5) |=> DAT_O == 8'h60)
      else $error("line status wrong after reset");
   a_ctrl_reset: assert property (s_fresh_rd(3'h3) or s_fresh_rd(3'h4) or s_fresh_rd(3'h1)
      |=> DAT_O == 8'h00) else $error("control register not cleared");
   a_msr_reset: assert property (s_fresh_rd(3'h6) |=> DAT_O[3:0] == 4'h0)
      else $error("modem change bits set after reset");
endmodule // ubg_uart_properties
bind ubg_uart ubg_uart_properties i_props (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .DAT_I(DAT_I), .DAT_O(DAT_O), .CS_I(CS_I), .RD_I(RD_I), .WR_I(WR_I),
   .SERIAL_OUTPUT_O(SERIAL_OUTPUT_O), .BAUD_CLOCK_OUT_O(BAUD_CLOCK_OUT_O),
   .DTR_N_O(DTR_N_O), .RTS_N_O(RTS_N_O), .USER_OUTPUT_ONE_N_O(USER_OUTPUT_ONE_N_O),
   .USER_OUTPUT_TWO_N_O(USER_OUTPUT_TWO_N_O), .INTR_O(INTR_O));

/* tb/ubg_host_model.sv */
`timescale 1ns/1ns
// cpu on the register bus; two clocks per access, never back to back
module ubg_host_model (
   input wire clk_i,
   output reg cs_o = 1'b0,
   output reg rd_o = 1'b0,
   output reg wr_o = 1'b0,
   output reg [2:0] addr_o = 3'h0,
   output reg [7:0] dat_o = 8'h00
);
   // request held until the edge that takes it, data scrambled after
   task acc(input w, input [2:0] a, input [7:0] d);
      begin
         cs_o <= 1'b1;
         wr_o <= w;
         rd_o <= !w;
         addr_o <= a;
         dat_o <= d;
         @(posedge clk_i);
         cs_o <= 1'b0;
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         dat_o <= ~d;
         @(posedge clk_i);
      end
   endtask
   // divisor behind the select bit, frame format after it
   task prog(input [15:0] v);
      begin
         acc(1'b1, 3'h3, 8'h80);
         acc(1'b1, 3'h0, v[7:0]);
         acc(1'b1, 3'h1, v[15:8]);
         acc(1'b1, 3'h3, 8'h03);
      end
   endtask
endmodule // ubg_host_model

/* tb/ubg_uart_bench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module ubg_uart_bench;
   reg CLK_I = 1'b0;
   reg RST_I = 1'b1;
   reg cts_n = 1'b0;
   wire cs, rd, wr, serial_output, bclk, dtr_n, rts_n, o1_n, o2_n, intr;
   wire [2:0] addr;
   wire [7:0] di;
   wire [7:0] dout;
   int n_fail = 0;
   int cmp_count = 0;
   int p;
   int i;
   reg [15:0] dv [0:5] = '{16'h0001, 16'h000c, 16'h0010, 16'h0004, 16'h0014, 16'h0f00};
   int per [0:5] = '{1, 12, 16, 4, 20, 3840};
   ubg_uart i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(addr), .DAT_I(di), .DAT_O(dout),
      .CS_I(cs), .RD_I(rd), .WR_I(wr), .SERIAL_IN_I(1'b1), .CTS_N_I(cts_n), .DSR_N_I(1'b0),
      .RI_N_I(1'b1), .DCD_N_I(1'b0), .SERIAL_OUTPUT_O(serial_output), .BAUD_CLOCK_OUT_O(bclk),
      .DTR_N_O(dtr_n), .RTS_N_O(rts_n), .USER_OUTPUT_ONE_N_O(o1_n),
      .USER_OUTPUT_TWO_N_O(o2_n), .INTR_O(intr));
   ubg_host_model i_host (.clk_i(CLK_I), .cs_o(cs), .rd_o(rd), .wr_o(wr), .addr_o(addr),
      .dat_o(di));
   // 50 MHz
   always #10 CLK_I = ~CLK_I;
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // eight quiet clocks after release so the idle check sees no writes
   task do_reset;
      begin
         RST_I <= 1'b1;
         repeat (16) @(posedge CLK_I);
         RST_I <= 1'b0;
         repeat (8) @(posedge CLK_I);
      end
   endtask
   // clocks between two pulses, sampled on the quiet edge
   task meas(output int n);
      int k;
      int s;
      begin
         n = 0;
         s = 0;
         for (k = 0; k < 8000 && s < 2; k++) begin
            @(negedge CLK_I);
            if (s == 1) n++;
            if (bclk === 1'b1) s++;
         end
         if (s < 2) begin
            n_fail++;
            print_verdict;
         end
         @(posedge CLK_I);
      end
   endtask
   task rdchk(input [2:0] a, input [7:0] e);
      begin
         i_host.acc(1'b0, a, 8'h00);
         `CHK(dout, e);
      end
   endtask
   initial begin
      do_reset;
      rdchk(3'h2, 8'h01);
      rdchk(3'h5, 8'h60);
      rdchk(3'h1, 8'h00);
      rdchk(3'h3, 8'h00);
      rdchk(3'h6, 8'hb0);
      `CHK({dtr_n, rts_n, o1_n, o2_n, serial_output}, 5'h1f);
      // one row per divisor
      for (i = 0; i < 6; i++) begin
         i_host.prog(dv[i]);
         meas(p);
         `CHK(p, per[i]);
      end
      i_host.acc(1'b1, 3'h4, 8'h0f);
      `CHK({dtr_n, rts_n, o1_n, o2_n}, 4'h0);
      do_reset;
      `CHK({dtr_n, rts_n, o1_n, o2_n}, 4'hf);
      rdchk(3'h4, 8'h00);
      i_host.acc(1'b1, 3'h3, 8'h80);
      rdchk(3'h0, 8'h00);
      rdchk(3'h1, 8'h0f);
      rdchk(3'h3, 8'h80);
      i_host.acc(1'b1, 3'h3, 8'h00);
      i_host.acc(1'b1, 3'h1, 8'h02);
      `CHK(intr, 1'b1);
      rdchk(3'h2, 8'h02);
      `CHK(intr, 1'b0);
      do_reset;
      i_host.acc(1'b1, 3'h1, 8'h02);
      `CHK(intr, 1'b1);
      i_host.acc(1'b1, 3'h0, 8'h55);
      `CHK(intr, 1'b0);
      // loop mode at full rate, one character returns within about 160 clocks
      do_reset;
      i_host.prog(16'h0001);
      i_host.acc(1'b1, 3'h4, 8'h10);
      i_host.acc(1'b1, 3'h0, 8'ha5);
      repeat (200) @(posedge CLK_I);
      rdchk(3'h5, 8'h61);
      i_host.acc(1'b1, 3'h1, 8'h01);
      `CHK(intr, 1'b1);
      rdchk(3'h0, 8'ha5);
      `CHK(intr, 1'b0);
      rdchk(3'h5, 8'h60);
      // clear-to-send change raises a modem interrupt until status is read
      i_host.acc(1'b1, 3'h1, 8'h08);
      cts_n <= 1'b1;
      repeat (2) @(posedge CLK_I);
      `CHK(intr, 1'b1);
      rdchk(3'h6, 8'ha1);
      `CHK(intr, 1'b0);
      // a pending change is dropped by reset
      cts_n <= 1'b0;
      repeat (2) @(posedge CLK_I);
      do_reset;
      rdchk(3'h6, 8'hb0);
      print_verdict;
   end
endmodule // ubg_uart_bench
